// >>> shared/twsp_regs.vh
`ifndef TWSP_REGS_VH
`define TWSP_REGS_VH
// Register word offsets (byte addresses on the bus).
`define TWSP_OFS_CTRL1 6'h00
`define TWSP_OFS_CTRL2 6'h04
`define TWSP_OFS_STATUS 6'h08
`define TWSP_OFS_BUF 6'h0c
`define TWSP_OFS_ADDR 6'h10
// Status field positions.
`define TWSP_ST_SLEW 7
`define TWSP_ST_SMBUS 6
`define TWSP_ST_DATA 5
`define TWSP_ST_STOP 4
`define TWSP_ST_START 3
`define TWSP_ST_READ 2
`define TWSP_ST_UPDADDR 1
`define TWSP_ST_FULL 0
// Control one field positions.
`define TWSP_C1_WRITE_COLLISION_FLAG 7
`define TWSP_C1_OVF 6
`define TWSP_C1_EN 5
`define TWSP_C1_REL 4
// Role codes.
`define TWSP_ROLE_S7 4'h6
`define TWSP_ROLE_S10 4'h7
`define TWSP_ROLE_M 4'h8
// Reset values.
`define TWSP_RST_CTRL1 8'h00
`define TWSP_RST_CTRL2 8'h00
`define TWSP_RST_STATUS 8'h00
`define TWSP_RST_ADDR 8'h00
// General call address byte.
`define TWSP_GCALL 8'h00
`endif

// >>> design/twsp_core.v
// How it works
// - Master and slave roles, general call recognised.
// - Seven and ten bit slave addressing.
// - Start and stop detection raise events.
// - Only clock and data lines carry traffic.
// - Shift register hidden from software.
// - Both control registers read and write.
// - Status low six read-only, top two writable.
// - Slave role compares own address register.
// - Master uses low seven bits as reload.
// - Completed byte goes to buffer, flag set.
// - Buffer write loads buffer, and shifter only when not shifting out.
// - Status bit seven selects slew control.
// - Status bit six enables bus thresholds.
// - Role field selects slave7, slave10, master.
// - Sticky overflow when unread byte overwritten.
// - Sticky collision on write while shifting out.
`timescale 1ns/10ps
`default_nettype none
`include "twsp_regs.vh"
module twsp_core #(
   parameter RELOAD_W = 7
) (
   input wire clk_sys_i,
   input wire sys_rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   output reg wb_err_o,
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe_o,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe_o,
   output reg port_event_flag_o,
   output reg slew_limit_o,
   output reg smbus_levels_o
);
   localparam ST_IDLE = 4'h1;
   localparam ST_ADDR = 4'h2;
   localparam ST_DATA = 4'h4;
   localparam ST_WAIT = 4'h8;

   reg [7:0] port_control_one;
   reg [7:0] port_control_two;
   reg [7:0] serial_port_status;
   reg [7:0] transfer_buffer;
   reg [7:0] address_or_reload;
   reg [7:0] bit_shifter;
   reg [2:0] scl_s;
   reg [2:0] sda_s;
   reg scl_q;
   reg sda_q;
   reg scl_prev;
   reg sda_prev;
   reg [3:0] state;
   reg [3:0] bit_cnt;
   reg tx_busy;
   reg hi_addr;
   reg [RELOAD_W+1:0] brg_cnt;
   reg brg_tick;
   reg [1:0] m_phase;

   wire en = port_control_one[`TWSP_C1_EN];
   wire [3:0] role = port_control_one[3:0];
   wire is_slave = (role == `TWSP_ROLE_S7) || (role == `TWSP_ROLE_S10);
   wire is_master = (role == `TWSP_ROLE_M);
   wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire wr = bus_req && wb_we_i && wb_sel_i[0];
   wire rd = bus_req && !wb_we_i;
   wire map_hit = (wb_adr_i == `TWSP_OFS_CTRL1) ||
      (wb_adr_i == `TWSP_OFS_CTRL2) || (wb_adr_i == `TWSP_OFS_STATUS) ||
      (wb_adr_i == `TWSP_OFS_BUF) || (wb_adr_i == `TWSP_OFS_ADDR);
   wire buf_wr = wr && (wb_adr_i == `TWSP_OFS_BUF);
   wire buf_rd = rd && (wb_adr_i == `TWSP_OFS_BUF);
   wire scl_rise = scl_q && !scl_prev;
   wire scl_fall = !scl_q && scl_prev;
   wire start_det = en && scl_q && scl_prev && sda_prev && !sda_q;
   wire stop_det = en && scl_q && scl_prev && !sda_prev && sda_q;
   wire [7:0] rx_byte = {bit_shifter[6:0], sda_q};
   wire byte_done = scl_rise && (bit_cnt == 4'h7) &&
      ((state == ST_ADDR) || (state == ST_DATA));
   wire addr7_hit = (rx_byte[7:1] == address_or_reload[7:1]);
   wire addr10_hit = (rx_byte[7:3] == 5'h1e) &&
      (rx_byte[2:1] == address_or_reload[2:1]);
   wire gcall_hit = (rx_byte == `TWSP_GCALL);
   wire addr_hit = gcall_hit || ((role == `TWSP_ROLE_S7) ? addr7_hit :
      (hi_addr ? (rx_byte == address_or_reload) : addr10_hit));

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_prev <= 1'b1;
         sda_prev <= 1'b1;
      end else begin
         scl_s <= {scl_s[1:0], scl_i};
         sda_s <= {sda_s[1:0], sda_i};
         if (scl_s[1] == scl_s[2]) begin
            scl_q <= scl_s[2];
         end
         if (sda_s[1] == sda_s[2]) begin
            sda_q <= sda_s[2];
         end
         scl_prev <= scl_q;
         sda_prev <= sda_q;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i || !is_master || !en) begin
         brg_cnt <= {(RELOAD_W+2){1'b0}};
         brg_tick <= 1'b0;
      end else if (brg_cnt == {address_or_reload[RELOAD_W-1:0], 2'b11}) begin
         brg_cnt <= {(RELOAD_W+2){1'b0}};
         brg_tick <= 1'b1;
      end else begin
         brg_cnt <= brg_cnt + 1'b1;
         brg_tick <= 1'b0;
      end
   end

   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         port_control_one <= `TWSP_RST_CTRL1;
         port_control_two <= `TWSP_RST_CTRL2;
         serial_port_status <= `TWSP_RST_STATUS;
         transfer_buffer <= 8'h00;
         address_or_reload <= `TWSP_RST_ADDR;
         bit_shifter <= 8'h00;
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         tx_busy <= 1'b0;
         hi_addr <= 1'b0;
         m_phase <= 2'h0;
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0;
         scl_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         port_event_flag_o <= 1'b0;
         slew_limit_o <= 1'b0;
         smbus_levels_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req && map_hit;
         wb_err_o <= bus_req && !map_hit;
         port_event_flag_o <= 1'b0;
         slew_limit_o <= !serial_port_status[`TWSP_ST_SLEW];
         smbus_levels_o <= serial_port_status[`TWSP_ST_SMBUS];
         if (rd) begin
            case (wb_adr_i)
               `TWSP_OFS_CTRL1: wb_dat_o <= {24'h0, port_control_one};
               `TWSP_OFS_CTRL2: wb_dat_o <= {24'h0, port_control_two};
               `TWSP_OFS_STATUS: wb_dat_o <= {24'h0, serial_port_status};
               `TWSP_OFS_BUF: wb_dat_o <= {24'h0, transfer_buffer};
               `TWSP_OFS_ADDR: wb_dat_o <= {24'h0, address_or_reload};
               default: wb_dat_o <= 32'h0;
            endcase
         end
         if (wr && wb_adr_i == `TWSP_OFS_CTRL1) begin
            port_control_one <= wb_dat_i[7:0];
         end
         if (wr && wb_adr_i == `TWSP_OFS_CTRL2) begin
            port_control_two <= wb_dat_i[7:0];
         end
         // only top two status bits writable
         if (wr && wb_adr_i == `TWSP_OFS_STATUS) begin
            serial_port_status[7:6] <= wb_dat_i[7:6];
         end
         if (wr && wb_adr_i == `TWSP_OFS_ADDR) begin
            address_or_reload <= wb_dat_i[7:0];
            serial_port_status[`TWSP_ST_UPDADDR] <= 1'b0;
         end
         if (buf_rd) begin
            serial_port_status[`TWSP_ST_FULL] <= 1'b0;
         end
         if (buf_wr) begin
            transfer_buffer <= wb_dat_i[7:0];
            if (tx_busy) begin
               port_control_one[`TWSP_C1_WRITE_COLLISION_FLAG] <= 1'b1;
            end else begin
               bit_shifter <= wb_dat_i[7:0];
               tx_busy <= 1'b1;
               bit_cnt <= 4'h0;
               serial_port_status[`TWSP_ST_FULL] <= 1'b1;
            end
         end
         if (start_det) begin
            serial_port_status[`TWSP_ST_START] <= 1'b1;
            serial_port_status[`TWSP_ST_STOP] <= 1'b0;
            port_event_flag_o <= 1'b1;
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            hi_addr <= 1'b0;
         end else if (stop_det) begin
            serial_port_status[`TWSP_ST_STOP] <= 1'b1;
            serial_port_status[`TWSP_ST_START] <= 1'b0;
            port_event_flag_o <= 1'b1;
            state <= ST_IDLE;
            tx_busy <= 1'b0;
            sda_oe_o <= 1'b0;
         end else if (!en) begin
            state <= ST_IDLE;
            tx_busy <= 1'b0;
            sda_oe_o <= 1'b0;
            scl_oe_o <= 1'b0;
            serial_port_status[`TWSP_ST_STOP] <= 1'b0;
            serial_port_status[`TWSP_ST_START] <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  sda_oe_o <= 1'b0;
               end
               ST_ADDR, ST_DATA: begin
                  if (scl_rise && !byte_done) begin
                     bit_shifter <= rx_byte;
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  // The acknowledge pull must end on the slot's falling clock.
                  if (scl_fall) begin
                     sda_oe_o <= tx_busy && !bit_shifter[7];
                  end
                  if (byte_done) begin
                     bit_cnt <= 4'h0;
                     state <= ST_WAIT;
                     if (tx_busy) begin
                        tx_busy <= 1'b0;
                        port_event_flag_o <= 1'b1;
                     end else if (state == ST_DATA || addr_hit) begin
                        transfer_buffer <= rx_byte;
                        port_event_flag_o <= 1'b1;
                        serial_port_status[`TWSP_ST_FULL] <= 1'b1;
                        if (serial_port_status[`TWSP_ST_FULL]) begin
                           port_control_one[`TWSP_C1_OVF] <= 1'b1;
                        end
                        // data or address, read or write
                        serial_port_status[`TWSP_ST_DATA] <=
                           (state == ST_DATA);
                        if (state == ST_ADDR && !hi_addr) begin
                           serial_port_status[`TWSP_ST_READ] <= rx_byte[0];
                        end
                        if (role == `TWSP_ROLE_S10 && state == ST_ADDR) begin
                           serial_port_status[`TWSP_ST_UPDADDR] <= 1'b1;
                        end
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_WAIT: begin
                  // Acknowledge slot: slave role pulls data low unless the read status bit is set.
                  if (scl_fall) begin
                     sda_o <= 1'b0;
                     sda_oe_o <= is_slave && !serial_port_status[2];
                  end
                  if (scl_rise) begin
                     hi_addr <= (role == `TWSP_ROLE_S10) && !hi_addr;
                     if (role == `TWSP_ROLE_S10 && !hi_addr &&
                        !serial_port_status[`TWSP_ST_DATA]) begin
                        state <= ST_ADDR;
                     end else begin
                        state <= ST_DATA;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
         // master clock drive from role select
         if (en && is_master && brg_tick) begin
            m_phase <= m_phase + 2'h1;
            scl_o <= 1'b0;
            scl_oe_o <= tx_busy && !m_phase[1];
         end else if (!en || !is_master) begin
            scl_oe_o <= is_slave && en && !port_control_one[`TWSP_C1_REL];
         end
      end
   end
endmodule
`default_nettype wire

// >>> verification/twsp_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "twsp_regs.vh"
module twsp_chk (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic wb_err_o,
   input wire logic scl_o,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic port_event_flag_o,
   input wire logic slew_limit_o,
   input wire logic smbus_levels_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   wire req = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
   wire hit = (wb_adr_i <= `TWSP_OFS_ADDR) && (wb_adr_i[1:0] == 2'h0);
   wire stw = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TWSP_OFS_STATUS);
   map_ack_a: assert property (req & hit |=> wb_ack_o & !wb_err_o)
      else $error("mapped access not acknowledged");
   unmap_err_a: assert property (req & !hit |=> wb_err_o & !wb_ack_o)
      else $error("unmapped access not refused");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   read_upper_a: assert property (wb_ack_o & !wb_we_i |->
      wb_dat_o[31:8] == 24'h0) else $error("upper read bits not zero");
   slew_ctrl_a: assert property (stw |-> ##2
      slew_limit_o == !$past(wb_dat_i[7], 2)) else $error("slew output wrong");
   smbus_sel_a: assert property (stw |-> ##2
      smbus_levels_o == $past(wb_dat_i[6], 2)) else $error("smbus output wrong");
   drain_only_a: assert property (!scl_o && !sda_o)
      else $error("pin driven high");
   evt_pulse_a: assert property (port_event_flag_o |=> !port_event_flag_o)
      else $error("event flag longer than one cycle");
   cover property (port_event_flag_o);
   cover property (wb_err_o);
   cover property (sda_oe_o);
endmodule
`default_nettype wire

// >>> verification/twsp_peer.sv
`timescale 1ns/10ps
`default_nettype none
module twsp_peer #(parameter int HALF = 25) (
   input wire logic clk_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_dn_o,
   output logic sda_dn_o
);
   initial scl_dn_o = 1'b0;
   initial sda_dn_o = 1'b0;
   task tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One bit; a slave that stretches the clock is waited for.
   task clk_bit(input logic b, output logic s);
      sda_dn_o <= !b;
      tick(HALF);
      scl_dn_o <= 1'b0;
      tick(HALF);
      while (!scl_i) tick(1);
      s = sda_i;
      scl_dn_o <= 1'b1;
      tick(4);
   endtask
   task send(input logic [7:0] v, output logic nk);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(v[i], s);
      clk_bit(1'b1, nk);
   endtask
   task frame(input logic [7:0] a, input logic [7:0] d, input logic wd,
         output logic [1:0] nk);
      sda_dn_o <= 1'b1;
      tick(HALF);
      scl_dn_o <= 1'b1;
      tick(4);
      nk[0] = 1'b1;
      send(a, nk[1]);
      if (wd)
         send(d, nk[0]);
      sda_dn_o <= 1'b1;
      tick(HALF);
      scl_dn_o <= 1'b0;
      tick(HALF);
      sda_dn_o <= 1'b0;
      tick(HALF);
   endtask
endmodule
`default_nettype wire

// >>> verification/test_twsp_core.sv
`timescale 1ns/10ps
`default_nettype none
`include "twsp_regs.vh"
module test_twsp_core;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [3:0] sel = 4'h1;
   logic [5:0] adr = 6'h00;
   logic [31:0] wdat = 32'h0;
   wire [31:0] rdat;
   wire ack, err, scl_oe, sda_oe, p_scl, p_sda, evt, slew, smb, scl_o, sda_o;
   wire scl = !(scl_oe | p_scl);
   wire sda = !(sda_oe | p_sda);
   int miscompares = 0;
   int checked = 0;
   int cycles = 0;
   int events = 0;
   logic [7:0] q;
   logic e;
   logic [1:0] nk;
   logic [3:0] roles [3] = '{`TWSP_ROLE_S7, `TWSP_ROLE_S10, `TWSP_ROLE_M};
   twsp_core twsp_core_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .port_event_flag_o(evt), .slew_limit_o(slew), .smbus_levels_o(smb));
   twsp_peer twsp_peer_i (.clk_i(clk_sys_i), .scl_i(scl), .sda_i(sda),
      .scl_dn_o(p_scl), .sda_dn_o(p_sda));
   initial forever #2.5 clk_sys_i = !clk_sys_i;
   always @(posedge clk_sys_i) begin
      cycles++;
      if (evt === 1'b1)
         events++;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up;
      end
   end
   task wrap_up;
      $display("checked=%0d miscompares=%0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      @(posedge clk_sys_i);
      while (!(ack | err)) @(posedge clk_sys_i);
      q = rdat[7:0];
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task rd(input logic [5:0] a, input logic [7:0] x);
      wb(1'b0, a, 8'h00);
      chk(q, x);
   endtask
   initial begin
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_sys_i);
      chk({scl_oe, sda_oe}, 2'b00);
      rd(`TWSP_OFS_CTRL1, `TWSP_RST_CTRL1);
      rd(`TWSP_OFS_STATUS, `TWSP_RST_STATUS);
      rd(`TWSP_OFS_ADDR, `TWSP_RST_ADDR);
      wb(1'b1, `TWSP_OFS_CTRL2, 8'ha5);
      rd(`TWSP_OFS_CTRL2, 8'ha5);
      wb(1'b1, 6'h14, 8'hff);
      chk(e, 1'b1);
      foreach (roles[i]) begin
         wb(1'b1, `TWSP_OFS_CTRL1, {4'h2, roles[i]});
         rd(`TWSP_OFS_CTRL1, {4'h2, roles[i]});
      end
      wb(1'b1, `TWSP_OFS_STATUS, 8'hff);
      rd(`TWSP_OFS_STATUS, 8'hc0);
      chk({slew, smb}, 2'b01);
      wb(1'b1, `TWSP_OFS_STATUS, 8'h00);
      rd(`TWSP_OFS_STATUS, 8'h00);
      chk({slew, smb}, 2'b10);
      wb(1'b1, `TWSP_OFS_ADDR, 8'h84);
      wb(1'b1, `TWSP_OFS_CTRL1, {4'h3, `TWSP_ROLE_S7});
      events = 0;
      twsp_peer_i.frame(8'h84, 8'h00, 1'b0, nk);
      chk(nk, 2'b01);
      chk(events, 3);
      rd(`TWSP_OFS_STATUS, 8'h11);
      rd(`TWSP_OFS_BUF, 8'h84);
      rd(`TWSP_OFS_STATUS, 8'h10);
      twsp_peer_i.frame(8'h84, 8'h5a, 1'b1, nk);
      chk(nk, 2'b00);
      rd(`TWSP_OFS_CTRL1, 8'h76);
      rd(`TWSP_OFS_STATUS, 8'h31);
      wb(1'b1, `TWSP_OFS_CTRL1, 8'h36);
      rd(`TWSP_OFS_CTRL1, 8'h36);
      events = 0;
      twsp_peer_i.frame(8'h90, 8'h00, 1'b0, nk);
      chk(nk, 2'b11);
      chk(events, 2);
      twsp_peer_i.frame(8'h00, 8'h00, 1'b0, nk);
      chk(nk, 2'b01);
      rd(`TWSP_OFS_BUF, 8'h00);
      rd(`TWSP_OFS_CTRL1, 8'h76);
      wb(1'b1, `TWSP_OFS_BUF, 8'h3c);
      rd(`TWSP_OFS_BUF, 8'h3c);
      wb(1'b1, `TWSP_OFS_BUF, 8'hc3);
      rd(`TWSP_OFS_CTRL1, 8'hf6);
      wrap_up;
   end
endmodule
bind twsp_core twsp_chk twsp_chk_i (.clk_sys_i(clk_sys_i),
   .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .wb_err_o(wb_err_o), .scl_o(scl_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .port_event_flag_o(port_event_flag_o), .slew_limit_o(slew_limit_o),
   .smbus_levels_o(smbus_levels_o));
`default_nettype wire
